//--- cpsb_pkg.sv
// Package for the control port and slave bus block.
// Assumes byte-wide registers on a plain strobe port.
package cpsb_pkg;
  localparam logic [7:0] ADDR_DATA_LATCH   = 8'h08;
  localparam logic [7:0] ADDR_CONTROL_PORT = 8'h09;
  localparam logic [7:0] ADDR_DATA_DIR     = 8'h88;
  localparam logic [7:0] ADDR_CTRL_DIR     = 8'h89;
  localparam logic [7:0] ADDR_ANALOG_CFG   = 8'h9F;
  localparam int         BIT_IN_FULL       = 7;
  localparam int         BIT_OUT_FULL      = 6;
  localparam int         BIT_OVERFLOW      = 5;
  localparam int         BIT_MODE          = 4;
  localparam logic [7:0] DATA_DIR_RST      = 8'hFF;
  localparam logic [2:0] CTRL_DIR_RST      = 3'h7;
  localparam logic [2:0] ANALOG_CFG_RST    = 3'h0;
  localparam logic [2:0] ANALOG_CFG_DIGITAL = 3'h7;
  localparam int         SYNC_STAGES       = 2;
endpackage : cpsb_pkg

//--- cpsb_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes the pins are levels held longer than two clock periods.
`timescale 1ns/1ps
module cpsb_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         core_clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         en_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] stage1_reg;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stage1_reg <= RST_VAL;
      sync_o     <= RST_VAL;
    end else if (en_i) begin
      stage1_reg <= async_i;
      sync_o     <= stage1_reg;
    end
  end
endmodule : cpsb_sync

//--- cpsb_top.sv
// Control port with parallel slave bus: registers, pins and flags.
// Assumes a CPU register port on core_clk_i and an external asynchronous master.
//
// Summary of operation
// - Three control pins, each separately set as input or output.
// - Slave-bus mode turns the control pins into read, write, select inputs.
// - A control pin configured analog reads back as zero.
// - Direction bits still drive pin direction while a pin is analog.
// - After power-on the control pins are analog and read zero.
// - Read strobe low with select low drives the data latch out.
// - Write strobe low with select low captures data pins into input latch.
// - Select is active low; unselected, both strobes are ignored.
// - Output-full flag set by CPU write, cleared when master reads.
// - Overflow set on write over unread byte; cleared by software zero.
// - Mode select bit: one slave bus, zero plain port; resets zero.
// - Low three direction bits: one input, zero output; reset to one.
// - Data pin direction register resets to all ones.
// - Write completion sets input-full and interrupt flag after synchroniser delay.
// - Input-full clears on a CPU read of the data latch, or whenever slave-bus mode is off.
// - Output-full clears when external read begins, stays clear until CPU write.
// - Outside slave-bus mode full flags are zero; overflow stays.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module cpsb_top (
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       clk_en_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic [7:0] data_pins_i,
  output logic      [7:0] data_pins_o,
  output logic      [7:0] data_pins_oe_n_o,
  input  wire logic [2:0] ctrl_pins_i,
  output logic      [2:0] ctrl_pins_o,
  output logic      [2:0] ctrl_pins_oe_n_o,
  output logic            slave_bus_irq_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] out_latch_reg;
  logic [7:0] in_latch_reg;
  logic [7:0] data_dir_reg;
  logic [2:0] ctrl_dir_reg;
  logic [2:0] ctrl_out_reg;
  logic [2:0] analog_cfg_reg;
  logic       mode_reg;
  logic       in_full_reg;
  logic       out_full_reg;
  logic       overflow_reg;
  logic       irq_reg;
  logic [7:0] rdata_reg;
  logic       wr_active_reg;
  logic       rd_active_reg;
  logic [7:0] data_sync1_reg;
  logic [7:0] data_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pins
  logic [2:0] ctrl_sync;
  cpsb_sync #(.W(3), .RST_VAL(3'h7)) u_ctrl_sync (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .en_i       (clk_en_i),
    .async_i    (ctrl_pins_i),
    .sync_o     (ctrl_sync)
  );

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_sync1_reg <= 8'h00;
      data_sync_reg  <= 8'h00;
    end else if (clk_en_i) begin
      data_sync1_reg <= data_pins_i;
      data_sync_reg  <= data_sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  // One compare shared by every select so all registers decode alike
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  wire sel_data    = addr_hit(reg_addr_i, cpsb_pkg::ADDR_DATA_LATCH);
  wire sel_ctrl    = addr_hit(reg_addr_i, cpsb_pkg::ADDR_CONTROL_PORT);
  wire sel_ddir    = addr_hit(reg_addr_i, cpsb_pkg::ADDR_DATA_DIR);
  wire sel_cdir    = addr_hit(reg_addr_i, cpsb_pkg::ADDR_CTRL_DIR);
  wire sel_acfg    = addr_hit(reg_addr_i, cpsb_pkg::ADDR_ANALOG_CFG);
  wire wr_data     = reg_wr_i && sel_data;
  wire rd_data     = reg_rd_i && sel_data;
  wire wr_cdir     = reg_wr_i && sel_cdir;
  wire wr_ddir     = reg_wr_i && sel_ddir;
  wire wr_ctrl     = reg_wr_i && sel_ctrl;
  wire wr_acfg     = reg_wr_i && sel_acfg;

  // Pins count as digital only when analog config selects digital
  wire        pins_digital = (analog_cfg_reg == cpsb_pkg::ANALOG_CFG_DIGITAL);
  wire [2:0]  ctrl_read    = pins_digital ? ctrl_sync : 3'h0;

  wire rd_n_s  = ctrl_sync[0];
  wire wr_n_s  = ctrl_sync[1];
  wire cs_n_s  = ctrl_sync[2];
  wire bus_on  = mode_reg;
  wire wr_low  = bus_on && !cs_n_s && !wr_n_s;
  wire rd_low  = bus_on && !cs_n_s && !rd_n_s;
  // Raw pin read for drive: waiting for the synchroniser would clip the read window
  wire rd_drive = bus_on && !ctrl_pins_i[2] && !ctrl_pins_i[0];
  wire wr_done = wr_active_reg && !wr_low;
  wire rd_start = rd_low && !rd_active_reg;
  wire rd_done = rd_active_reg && !rd_low;

  ////////////////////////////////////////////////////////////////////////////
  // Slave bus transfer tracking
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_active_reg <= 1'b0;
      rd_active_reg <= 1'b0;
    end else if (clk_en_i) begin
      wr_active_reg <= wr_low;
      rd_active_reg <= rd_low;
    end
  end

  // Latch follows the pins for the whole strobe, so the last sample wins
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      in_latch_reg <= 8'h00;
    end else if (clk_en_i && wr_low) begin
      in_latch_reg <= data_sync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags; set wins over the strobe clears in the same cycle, whether hardware or software sets; mode off clears the full flags over a set
  wire in_full_set  = wr_done;
  wire in_full_clr  = rd_data;
  wire out_full_set = wr_data;
  wire out_full_clr = rd_start;
  // A read landing with the completion consumes the old byte, so no overflow
  wire ovf_set      = wr_done && in_full_reg && !rd_data;
  wire ovf_clr      = wr_cdir && !reg_wdata_i[cpsb_pkg::BIT_OVERFLOW];

  logic in_full_next;
  logic out_full_next;
  logic overflow_next;

  always_comb begin
    in_full_next = in_full_reg;
    if (in_full_clr) begin
      in_full_next = 1'b0;
    end
    if (in_full_set) begin
      in_full_next = 1'b1;
    end
    if (!bus_on) begin
      in_full_next = 1'b0;
    end
  end

  always_comb begin
    out_full_next = out_full_reg;
    if (out_full_clr) begin
      out_full_next = 1'b0;
    end
    if (out_full_set) begin
      out_full_next = 1'b1;
    end
    if (!bus_on) begin
      out_full_next = 1'b0;
    end
  end

  // Mode is not looked at: overflow outlives slave-bus mode
  always_comb begin
    overflow_next = overflow_reg;
    if (ovf_clr) begin
      overflow_next = 1'b0;
    end
    if (ovf_set) begin
      overflow_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      in_full_reg <= 1'b0;
    end else if (clk_en_i) begin
      in_full_reg <= in_full_next;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_full_reg <= 1'b0;
    end else if (clk_en_i) begin
      out_full_reg <= out_full_next;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      overflow_reg <= 1'b0;
    end else if (clk_en_i) begin
      overflow_reg <= overflow_next;
    end
  end

  // One-cycle completion pulse; the interrupt controller latches it
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_reg <= 1'b0;
    end else if (clk_en_i) begin
      irq_reg <= wr_done || rd_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software writable registers
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_latch_reg <= 8'h00;
    end else if (clk_en_i && wr_data) begin
      out_latch_reg <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_dir_reg <= cpsb_pkg::DATA_DIR_RST;
    end else if (clk_en_i && wr_ddir) begin
      data_dir_reg <= reg_wdata_i;
    end
  end

  // Status bits 7 and 6 are hardware owned; bit 5 is handled with the flags
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_dir_reg <= cpsb_pkg::CTRL_DIR_RST;
      mode_reg     <= 1'b0;
    end else if (clk_en_i && wr_cdir) begin
      ctrl_dir_reg <= reg_wdata_i[2:0];
      mode_reg     <= reg_wdata_i[cpsb_pkg::BIT_MODE];
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_out_reg <= 3'h0;
    end else if (clk_en_i && wr_ctrl) begin
      ctrl_out_reg <= reg_wdata_i[2:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      analog_cfg_reg <= cpsb_pkg::ANALOG_CFG_RST;
    end else if (clk_en_i && wr_acfg) begin
      analog_cfg_reg <= reg_wdata_i[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read back, one cycle after the strobe
  wire [7:0] ctrl_status = {in_full_reg, out_full_reg, overflow_reg, mode_reg, 1'b0, ctrl_dir_reg};
  wire [7:0] data_view   = bus_on ? in_latch_reg : data_sync_reg;
  wire [7:0] rd_mux =
    sel_data ? data_view :
    sel_ctrl ? {5'h00, ctrl_read} :
    sel_ddir ? data_dir_reg :
    sel_cdir ? ctrl_status :
    sel_acfg ? {5'h00, analog_cfg_reg} : 8'h00;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg <= 8'h00;
    end else if (clk_en_i) begin
      rdata_reg <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  assign reg_rdata_o          = rdata_reg;
  assign slave_bus_irq_flag_o = irq_reg;
  assign data_pins_o          = out_latch_reg;
  // Direction register is ignored in slave-bus mode
  assign data_pins_oe_n_o     = bus_on ? {8{!rd_drive}} : data_dir_reg;
  assign ctrl_pins_o          = ctrl_out_reg;
  // Direction bits govern even when analog; mode forces inputs
  assign ctrl_pins_oe_n_o     = bus_on ? 3'h7 : ctrl_dir_reg;

endmodule : cpsb_top

//--- cpsb_assertions.sv
// Port checker for cpsb_top.
// Assumes one clock domain; mode bit is tracked from register writes.
`timescale 1ns/1ps
module cpsb_assertions (
  input wire logic       core_clk_i,
  input wire logic       arst_n_i,
  input wire logic       clk_en_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] data_pins_o,
  input wire logic [7:0] data_pins_oe_n_o,
  input wire logic [2:0] ctrl_pins_i,
  input wire logic [2:0] ctrl_pins_oe_n_o,
  input wire logic       slave_bus_irq_flag_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i || !clk_en_i);
  ////////////////////////////////////////////////////////////////////////////
  logic mode_reg;
  wire  ctl_wr = reg_wr_i && (reg_addr_i == cpsb_pkg::ADDR_CTRL_DIR);
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) mode_reg <= 1'b0;
    else if (clk_en_i && ctl_wr) mode_reg <= reg_wdata_i[cpsb_pkg::BIT_MODE];
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_rd_drive; mode_reg && !ctrl_pins_i[2] && !ctrl_pins_i[0] |-> data_pins_oe_n_o == 8'h00; endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("data pins not driven on read");
  property p_unsel; mode_reg && ctrl_pins_i[2] |-> data_pins_oe_n_o == 8'hFF; endproperty
  a_unsel: assert property (p_unsel) else $error("data pins driven while unselected");
  property p_mode_ctrl; mode_reg |-> ctrl_pins_oe_n_o == 3'h7; endproperty
  a_mode_ctrl: assert property (p_mode_ctrl) else $error("control pins not inputs in slave mode");
  property p_ctrl_dir; ctl_wr && !reg_wdata_i[4] |=> ctrl_pins_oe_n_o == $past(reg_wdata_i[2:0]); endproperty
  a_ctrl_dir: assert property (p_ctrl_dir) else $error("control direction mismatch");
  property p_data_dir;
    reg_wr_i && reg_addr_i == cpsb_pkg::ADDR_DATA_DIR && !mode_reg |=> data_pins_oe_n_o == $past(reg_wdata_i);
  endproperty
  a_data_dir: assert property (p_data_dir) else $error("data direction mismatch");
  property p_latch; reg_wr_i && reg_addr_i == cpsb_pkg::ADDR_DATA_LATCH |=> data_pins_o == $past(reg_wdata_i); endproperty
  a_latch: assert property (p_latch) else $error("output latch not loaded");
  property p_rdata_idle; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_irq_pulse; slave_bus_irq_flag_o |=> !slave_bus_irq_flag_o; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("completion pulse too long");
  // Lower bound catches only a synchroniser with both stages missing; one stage short still passes
  property p_sync_done;
    mode_reg && !ctrl_pins_i[2] && ($rose(ctrl_pins_i[0]) || $rose(ctrl_pins_i[1])) |-> ##[2:5] slave_bus_irq_flag_o;
  endproperty
  a_sync_done: assert property (p_sync_done) else $error("completion pulse not in window");
endmodule : cpsb_assertions

bind cpsb_top cpsb_assertions cpsb_assertions_inst (.*);

//--- cpsb_ext_master.sv
// External byte-bus master model driving strobes and data pins.
// Assumes no pull on the data lines, so released data shows the inverse.
`timescale 1ns/1ps
module cpsb_ext_master (
  output logic [2:0] ctrl_n_o,
  output logic [7:0] data_o,
  input  wire logic [7:0] bus_i
);
  initial begin
    ctrl_n_o = 3'h7;
    data_o   = 8'h5A;
  end
  // Data set three cycles ahead since the slave synchronises it
  task automatic bus_write(input logic [7:0] d, input logic sel);
    data_o = d;
    #300 ctrl_n_o = {~sel, 2'b01};
    #600 ctrl_n_o[1] = 1'b1;
    #100 ctrl_n_o[2] = 1'b1;
    #200 data_o = ~d;
    #1000;
  endtask : bus_write
  task automatic bus_read(output logic [7:0] d);
    ctrl_n_o = 3'b010;
    #600 d = bus_i;
    ctrl_n_o[0] = 1'b1;
    #100 ctrl_n_o = 3'h7;
    #1000;
  endtask : bus_read
endmodule : cpsb_ext_master

//--- tb_top.sv
// Self-checking bench for cpsb_top: register tasks plus external master.
// Assumes the package constants and the note's one-cycle read slot.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  logic       core_clk_i = 1'b0;
  logic       arst_n_i   = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, rdata, ext_d, ext_rd;
  logic       reg_wr_i   = 1'b0, reg_rd_i = 1'b0, clk_en_i = 1'b1;
  logic [7:0] data_pins_i, data_pins_o, data_pins_oe_n_o;
  logic [2:0] ctrl_pins_i, ctrl_pins_o, ctrl_pins_oe_n_o, ext_ctrl;
  logic       irq;
  int         num_errors = 0, n_compared = 0, irq_cnt = 0;
  // Wire level from the DUT's enables; the master drives where the DUT releases
  assign data_pins_i = (data_pins_oe_n_o & ext_d) | (~data_pins_oe_n_o & data_pins_o);
  assign ctrl_pins_i = (ctrl_pins_oe_n_o & ext_ctrl) | (~ctrl_pins_oe_n_o & ctrl_pins_o);
  cpsb_top cpsb_top_inst (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(rdata), .data_pins_i(data_pins_i), .data_pins_o(data_pins_o),
    .data_pins_oe_n_o(data_pins_oe_n_o), .ctrl_pins_i(ctrl_pins_i), .ctrl_pins_o(ctrl_pins_o),
    .ctrl_pins_oe_n_o(ctrl_pins_oe_n_o), .slave_bus_irq_flag_o(irq));
  cpsb_ext_master cpsb_ext_master_inst (.ctrl_n_o(ext_ctrl), .data_o(ext_d), .bus_i(data_pins_i));
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) if (irq === 1'b1) irq_cnt++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a; reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 `CHK(rdata, e)
  endtask : rd
  task automatic close_out();
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000 num_errors++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    rd(8'h88, 8'hFF);
    rd(8'h89, 8'h07);
    rd(8'h09, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'h89, 8'h02);
    rd(8'h89, 8'h02);
    `CHK(ctrl_pins_oe_n_o, 3'h2)
    wr(8'h09, 8'h05);
    #1 `CHK(ctrl_pins_o, 3'h5)
    wr(8'h88, 8'h0F);
    rd(8'h88, 8'h0F);
    clk_en_i <= 1'b0;
    wr(8'h88, 8'h33);
    clk_en_i <= 1'b1;
    rd(8'h88, 8'h0F);
    wr(8'h9F, 8'h07);
    wr(8'h89, 8'h07);
    rd(8'h09, 8'h07);
    wr(8'h9F, 8'h00);
    rd(8'h09, 8'h00);
    `CHK(ctrl_pins_oe_n_o, 3'h7)
    wr(8'h9F, 8'h07);
    wr(8'h89, 8'hFF);
    rd(8'h89, 8'h17);
    wr(8'h08, 8'hA5);
    rd(8'h89, 8'h57);
    cpsb_ext_master_inst.bus_read(ext_rd);
    `CHK(ext_rd, 8'hA5)
    rd(8'h89, 8'h17);
    cpsb_ext_master_inst.bus_write(8'h3C, 1'b1);
    rd(8'h89, 8'h97);
    cpsb_ext_master_inst.bus_write(8'hC3, 1'b1);
    rd(8'h89, 8'hB7);
    rd(8'h08, 8'hC3);
    rd(8'h89, 8'h37);
    wr(8'h08, 8'h66);
    wr(8'h89, 8'h27);
    rd(8'h89, 8'h27);
    wr(8'h89, 8'h17);
    rd(8'h89, 8'h17);
    cpsb_ext_master_inst.bus_write(8'h11, 1'b0);
    rd(8'h89, 8'h17);
    `CHK(irq_cnt, 3)
    close_out();
  end
endmodule : tb_top
